/* File: fpl_top.sv */
// Front panel lock, remote lockout, view angle, time setup and wander path
module fpl_top
	import fpl_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYC
) (
	input  wire logic            sys_clk_i,
	input  wire logic            rst_i,
	// AXI4-Lite slave
	input  wire logic [AW-1:0]   s_axi_awaddr_i,
	input  wire logic            s_axi_awvalid_i,
	output logic                 s_axi_awready_o,
	input  wire logic [31:0]     s_axi_wdata_i,
	input  wire logic [3:0]      s_axi_wstrb_i,
	input  wire logic            s_axi_wvalid_i,
	output logic                 s_axi_wready_o,
	output logic [1:0]           s_axi_bresp_o,
	output logic                 s_axi_bvalid_o,
	input  wire logic            s_axi_bready_i,
	input  wire logic [AW-1:0]   s_axi_araddr_i,
	input  wire logic            s_axi_arvalid_i,
	output logic                 s_axi_arready_o,
	output logic [31:0]          s_axi_rdata_o,
	output logic [1:0]           s_axi_rresp_o,
	output logic                 s_axi_rvalid_o,
	input  wire logic            s_axi_rready_i,
	// Panel keys and controller line (asynchronous pins)
	input  wire logic [NKEY-1:0] key_i,
	input  wire logic            remote_lockout_i,
	// Wander path
	input  wire logic            ref_in_i,
	input  wire logic [PH_W-1:0] phase_sample_i,
	input  wire logic            phase_valid_i,
	input  wire logic            report_req_i,
	output logic                 ref_a_o,
	output logic                 ref_b_o,
	output logic [PH_W-1:0]      phase_filt_o,
	// Indicators
	output logic                 lock_led_o,
	output logic                 remote_led_o,
	output logic [1:0]           view_angle_o
);

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	logic [NSYNC-1:0] pins_s;

	fpl_sync #(
		.W (NSYNC)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.async_i   ({ref_in_i, remote_lockout_i, key_i}),
		.sync_o    (pins_s)
	);

	fpl_top_state_t s_q;
	fpl_top_state_t s_d;

	logic [NKEY-1:0] press;
	logic [NKEY-1:0] act;
	logic            rlo_rise;
	logic            tick;
	logic            in_menu;
	logic [NFLD-1:0] carry;
	fpl_time_t       edit_nx;
	fpl_time_t       run_nx;

	assign press    = pins_s[NKEY-1:0] & ~s_q.key_prev;
	assign rlo_rise = pins_s[S_RLO] & ~s_q.rlo_prev;
	assign tick     = (s_q.tick_cnt == TICK_W'(SEC_CYCLES - 1));
	assign in_menu  = (s_q.menu == ST_MENU);

	// Remote lockout masks everything but release; local lock masks all but lock
	always_comb begin
		if (s_q.remote) begin
			act = '0;
		end else if (s_q.locked) begin
			act = press & KEY_LOCK_MASK;
		end else begin
			act = press;
		end
	end

	// ---------------------------------------------------------------
	// Field steppers: edited snapshot and running clock
	// ---------------------------------------------------------------
	assign carry[F_SEC] = tick;

	for (genvar i = 0; i < NFLD; i++) begin : g_fld
		if (i < F_SEC) begin : g_carry
			// Ripple into next field only when the lower one wraps
			assign carry[i] = carry[i+1] & (s_q.now[i+1] == FLD_MAX[i+1]);
		end

		fpl_field_step u_edit (
			.val_i (s_q.edit[i]),
			.min_i (FLD_MIN[i]),
			.max_i (FLD_MAX[i]),
			.inc_i (in_menu & act[K_UP] & (s_q.sel == 3'(i))),
			.dec_i (in_menu & act[K_DOWN] & (s_q.sel == 3'(i))),
			.val_o (edit_nx[i])
		);

		fpl_field_step u_run (
			.val_i (s_q.now[i]),
			.min_i (FLD_MIN[i]),
			.max_i (FLD_MAX[i]),
			.inc_i (carry[i]),
			.dec_i (1'b0),
			.val_o (run_nx[i])
		);
	end

	// ---------------------------------------------------------------
	// Register read helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] pack_date(input fpl_time_t t);
		pack_date = {8'h00, 1'b0, t[0], 1'b0, t[1], 1'b0, t[2]};
	endfunction

	function automatic logic [31:0] pack_tod(input fpl_time_t t);
		pack_tod = {8'h00, 1'b0, t[3], 1'b0, t[4], 1'b0, t[5]};
	endfunction

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= REG_FILT);
	endfunction

	logic [31:0] rd_word;

	always_comb begin
		case (s_axi_araddr_i)
			REG_CTRL:       rd_word = {29'h0, s_q.ctrl};
			REG_STATUS:     rd_word = {23'h0, (s_q.ctrl[CTRL_FAM_A] != s_q.ctrl[CTRL_FAM_B]),
				s_q.sel, in_menu, s_q.view, s_q.remote, s_q.locked};
			REG_NOW_DATE:   rd_word = pack_date(s_q.now);
			REG_NOW_TOD:    rd_word = pack_tod(s_q.now);
			REG_EDIT_DATE:  rd_word = pack_date(s_q.edit);
			REG_EDIT_TOD:   rd_word = pack_tod(s_q.edit);
			REG_STAMP_DATE: rd_word = pack_date(s_q.stamp);
			REG_STAMP_TOD:  rd_word = pack_tod(s_q.stamp);
			REG_FILT:       rd_word = {16'h0, s_q.filt};
			default:        rd_word = 32'h0;
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	logic [ACC_W-1:0] diff;

	always_comb begin
		s_d  = s_q;
		diff = {phase_sample_i, ACC_FRAC} - s_q.acc;

		// AXI write: address and data taken in either order
		if (s_axi_awvalid_i && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata_i;
			s_d.wstrb  = s_axi_wstrb_i;
		end
		if (s_q.bvalid && s_axi_bready_i) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_q.awaddr == REG_CTRL && s_q.wstrb[0]) begin
				s_d.ctrl = s_q.wdata[2:0];
			end
		end
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;

		// AXI read: one-cycle answer
		if (s_q.rvalid && s_axi_rready_i) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_word;
			s_d.rresp  = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.arready = !s_d.rvalid;

		// Key edges
		s_d.key_prev = pins_s[NKEY-1:0];
		s_d.rlo_prev = pins_s[S_RLO];

		if (s_q.remote && press[K_REL]) begin
			s_d.remote = 1'b0;
		end
		// Lockout command after release so a same-cycle command wins
		if (rlo_rise) begin
			s_d.remote = 1'b1;
		end
		if (act[K_LOCK]) begin
			s_d.locked = !s_q.locked;
		end
		if (act[K_VIEW]) begin
			s_d.view = 2'(s_q.view + 1'b1);
		end

		// Running clock
		s_d.tick_cnt = tick ? '0 : TICK_W'(s_q.tick_cnt + 1'b1);
		s_d.now      = run_nx;

		// Time setup menu
		case (s_q.menu)
			ST_RUN: begin
				if (act[K_MENU]) begin
					s_d.menu = ST_MENU;
					s_d.edit = s_q.now;
					s_d.sel  = 3'h0;
				end
			end
			ST_MENU: begin
				s_d.edit = edit_nx;
				if (act[K_RIGHT]) begin
					s_d.sel = (s_q.sel == SEL_LAST) ? 3'h0 : 3'(s_q.sel + 1'b1);
				end else if (act[K_LEFT]) begin
					s_d.sel = (s_q.sel == 3'h0) ? SEL_LAST : 3'(s_q.sel - 1'b1);
				end
				if (act[K_ENTER]) begin
					s_d.now      = s_q.edit;
					s_d.tick_cnt = '0;
					s_d.menu     = ST_RUN;
				end else if (act[K_MENU]) begin
					s_d.menu = ST_RUN;
				end
			end
			default: begin
				s_d.menu = ST_RUN;
			end
		endcase

		// Report time stamp
		if (report_req_i) begin
			s_d.stamp = s_q.now;
		end

		// Wander phase filter
		if (phase_valid_i) begin
			s_d.acc  = ACC_W'(s_q.acc + ACC_W'($signed(diff) >>> FILT_SHIFT));
			s_d.filt = s_d.acc[ACC_W-1 -: PH_W];
		end

		// Reference pair: fixed delay in transient mode, otherwise aligned
		s_d.dly   = {s_q.dly[REF_DLY_CYC-2:0], pins_s[S_REF]};
		s_d.ref_a = pins_s[S_REF];
		s_d.ref_b = s_q.ctrl[CTRL_TRANSIENT] ? s_q.dly[REF_DLY_CYC-1] : pins_s[S_REF];
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q         <= '0;
			s_q.awready <= 1'b1;
			s_q.wready  <= 1'b1;
			s_q.arready <= 1'b1;
			s_q.menu    <= ST_RUN;
			s_q.now     <= FLD_MIN;
			s_q.edit    <= FLD_MIN;
			s_q.stamp   <= FLD_MIN;
			s_q.ctrl    <= CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign s_axi_awready_o = s_q.awready;
	assign s_axi_wready_o  = s_q.wready;
	assign s_axi_bvalid_o  = s_q.bvalid;
	assign s_axi_bresp_o   = s_q.bresp;
	assign s_axi_arready_o = s_q.arready;
	assign s_axi_rvalid_o  = s_q.rvalid;
	assign s_axi_rdata_o   = s_q.rdata;
	assign s_axi_rresp_o   = s_q.rresp;
	assign lock_led_o      = s_q.locked;
	assign remote_led_o    = s_q.remote;
	assign view_angle_o    = s_q.view;
	assign ref_a_o         = s_q.ref_a;
	assign ref_b_o         = s_q.ref_b;
	assign phase_filt_o    = s_q.filt;

endmodule // fpl_top

/* File: fpl_pkg.sv */
// Package: constants, types and register map of the front panel lock and clock setup block
//
// Operation
// - Each lock key press toggles panel lock; lock indicator lit while locked.
// - While locked, every key except the lock key is ignored.
// - Controller may command remote lockout; then only the release key acts.
// - Release key indicator lit exactly while remote lockout is active.
// - Release key press in lockout returns local control, indicator off, keys enabled.
// - Viewing-angle key steps through four settings, wrapping back to the first.
// - Clock holds year, month, day, hour, minute, second; hours 00 to 23.
// - Entering time menu snapshots date and time; snapshot frozen while menu shown.
// - Left/right move selected field; up/down step its value.
// - ENTER loads edited date and time into the running clock.
// - Every report carries current date and time from the internal clock.
// - Wander phase samples pass a 10 Hz low-pass filter first.
// - Transient mode delays second reference output by fixed 324 ns, nothing added; the code rounds up to 4 clock cycles, 400 ns.
package fpl_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_NS     = 100;
	localparam int SECOND_NS  = 1000000000;
	localparam int SEC_CYC    = SECOND_NS / CLK_NS;
	localparam int REF_DLY_NS = 324;
	localparam int REF_DLY_CYC = (REF_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W     = 24;

	// First-order IIR, alpha = 2^-5 ~ 2*pi*10 Hz / 2 kHz sample rate
	localparam int PHASE_FS_HZ = 2000;
	localparam int FILT_CORNER_HZ = 10;
	localparam int FILT_SHIFT = 5;
	localparam int PH_W       = 16;
	localparam int ACC_W      = 24;
	localparam logic [7:0] ACC_FRAC = 8'h00;

	// ---------------------------------------------------------------
	// Keys
	// ---------------------------------------------------------------
	localparam int NKEY    = 9;
	localparam int K_LOCK  = 0;
	localparam int K_REL   = 1;
	localparam int K_VIEW  = 2;
	localparam int K_MENU  = 3;
	localparam int K_LEFT  = 4;
	localparam int K_RIGHT = 5;
	localparam int K_UP    = 6;
	localparam int K_DOWN  = 7;
	localparam int K_ENTER = 8;
	localparam logic [NKEY-1:0] KEY_LOCK_MASK = 9'h001;
	localparam int NSYNC   = NKEY + 2;
	localparam int S_RLO   = NKEY;
	localparam int S_REF   = NKEY + 1;

	// ---------------------------------------------------------------
	// Time fields, index 0 = year .. 5 = second
	// ---------------------------------------------------------------
	localparam int NFLD   = 6;
	localparam int FLD_W  = 7;
	localparam int F_YEAR = 0;
	localparam int F_SEC  = 5;
	localparam logic [2:0] SEL_LAST = 3'h5;
	typedef logic [NFLD-1:0][FLD_W-1:0] fpl_time_t;
	localparam fpl_time_t FLD_MAX = {7'h3b, 7'h3b, 7'h17, 7'h1f, 7'h0c, 7'h63};
	localparam fpl_time_t FLD_MIN = {7'h00, 7'h00, 7'h00, 7'h01, 7'h01, 7'h00};

	typedef enum logic [0:0] {
		ST_RUN  = 1'b0,
		ST_MENU = 1'b1
	} fpl_menu_t;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int AW = 8;
	localparam logic [AW-1:0] REG_CTRL       = 8'h00;
	localparam logic [AW-1:0] REG_STATUS     = 8'h04;
	localparam logic [AW-1:0] REG_NOW_DATE   = 8'h08;
	localparam logic [AW-1:0] REG_NOW_TOD    = 8'h0c;
	localparam logic [AW-1:0] REG_EDIT_DATE  = 8'h10;
	localparam logic [AW-1:0] REG_EDIT_TOD   = 8'h14;
	localparam logic [AW-1:0] REG_STAMP_DATE = 8'h18;
	localparam logic [AW-1:0] REG_STAMP_TOD  = 8'h1c;
	localparam logic [AW-1:0] REG_FILT       = 8'h20;

	localparam int CTRL_TRANSIENT = 0;
	localparam int CTRL_FAM_A     = 1;
	localparam int CTRL_FAM_B     = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            aw_have;
		logic            w_have;
		logic [AW-1:0]   awaddr;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
		logic [NKEY-1:0] key_prev;
		logic            rlo_prev;
		logic            locked;
		logic            remote;
		logic [1:0]      view;
		fpl_menu_t       menu;
		logic [2:0]      sel;
		fpl_time_t       now;
		fpl_time_t       edit;
		fpl_time_t       stamp;
		logic [TICK_W-1:0] tick_cnt;
		logic [2:0]      ctrl;
		logic [ACC_W-1:0] acc;
		logic [PH_W-1:0] filt;
		logic [REF_DLY_CYC-1:0] dly;
		logic            ref_a;
		logic            ref_b;
	} fpl_top_state_t;

endpackage : fpl_pkg

/* File: fpl_sync.sv */
// Two-flop synchroniser for asynchronous panel and controller pins
module fpl_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} fpl_sync_state_t;

	fpl_sync_state_t s_q;
	fpl_sync_state_t s_d;

	always_comb begin
		s_d        = s_q;
		s_d.meta   = async_i;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.stable;

endmodule // fpl_sync

/* File: fpl_field_step.sv */
// One date or time field stepped up or down with wrap between its limits
module fpl_field_step
	import fpl_pkg::*;
(
	input  wire logic [FLD_W-1:0] val_i,
	input  wire logic [FLD_W-1:0] min_i,
	input  wire logic [FLD_W-1:0] max_i,
	input  wire logic             inc_i,
	input  wire logic             dec_i,
	output logic      [FLD_W-1:0] val_o
);

	always_comb begin
		val_o = val_i;
		if (inc_i) begin
			val_o = (val_i >= max_i) ? min_i : FLD_W'(val_i + 1'b1);
		end else if (dec_i) begin
			val_o = (val_i <= min_i) ? max_i : FLD_W'(val_i - 1'b1);
		end
	end

endmodule // fpl_field_step

/* File: fpl_top_sva.sv */
// Checker: lock, lockout and view-angle relations seen at the block's ports
module fpl_top_sva
	import fpl_pkg::*;
(
	input wire logic            sys_clk_i,
	input wire logic            rst_i,
	input wire logic [NKEY-1:0] key_i,
	input wire logic            remote_lockout_i,
	input wire logic            lock_led_o,
	input wire logic            remote_led_o,
	input wire logic [1:0]      view_angle_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// ---------------------------------------------------------------
	// A pin rise acts two edges after it is first sampled, seen one edge later
	// ---------------------------------------------------------------
	lock_toggle_a:
		assert property ($rose(key_i[K_LOCK]) ##2 !remote_led_o
			|=> $changed(lock_led_o)) else $error("lock press did not toggle");
	lock_cause_a:
		assert property ($changed(lock_led_o) |-> $past(key_i[K_LOCK], 3)
			&& !$past(key_i[K_LOCK], 4)) else $error("lock state moved without press");
	locked_ignore_a:
		assert property (lock_led_o && !remote_led_o |=> $stable(view_angle_o))
			else $error("view changed while locked");
	remote_ignore_a:
		assert property (remote_led_o |=> $stable(view_angle_o) && $stable(lock_led_o))
			else $error("key acted during lockout");
	remote_led_a:
		assert property ($rose(remote_lockout_i) |-> ##3 remote_led_o)
			else $error("lockout not shown");
	remote_cause_a:
		assert property ($rose(remote_led_o) |-> $past(remote_lockout_i, 3)
			&& !$past(remote_lockout_i, 4)) else $error("lockout led without command");
	release_a:
		assert property (($rose(key_i[K_REL]) && !$rose(remote_lockout_i)) ##2 remote_led_o
			|=> !remote_led_o) else $error("release key ignored");
	view_step_a:
		assert property ($changed(view_angle_o) |-> view_angle_o == $past(view_angle_o) + 2'h1)
			else $error("view skipped a setting");
	view_press_a:
		assert property ($rose(key_i[K_VIEW]) ##2 (!lock_led_o && !remote_led_o)
			|=> $changed(view_angle_o)) else $error("view press lost");
	reset_clear_a:
		assert property ($fell(rst_i) |-> !lock_led_o && !remote_led_o && view_angle_o == 2'h0)
			else $error("panel not clear after reset");

	cover property ($rose(lock_led_o));
	cover property ($fell(remote_led_o));
	cover property ($changed(view_angle_o) && view_angle_o == 2'h0);
endmodule // fpl_top_sva

bind fpl_top fpl_top_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .key_i(key_i),
	.remote_lockout_i(remote_lockout_i), .lock_led_o(lock_led_o),
	.remote_led_o(remote_led_o), .view_angle_o(view_angle_o));

/* File: fpl_panel_model.sv */
// Keypad and bus controller model driving the panel pins
module fpl_panel_model
	import fpl_pkg::*;
(
	input  wire logic            sys_clk_i,
	output logic      [NKEY-1:0] key_o,
	output logic                 remote_lockout_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		key_o = '0;
		remote_lockout_o = 1'b0;
	end

	// Held past the synchroniser, then low long enough for the next press
	task automatic press(input int k);
		@(posedge sys_clk_i);
		key_o[k] <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		key_o[k] <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask

	// Controller command is a level; only its rise enters lockout
	task automatic lockout(input logic v);
		@(posedge sys_clk_i);
		remote_lockout_o <= v;
		repeat (6) @(posedge sys_clk_i);
	endtask
endmodule // fpl_panel_model

/* File: fpl_top_tb.sv */
// Bench: register access, panel keys, time setup and wander path
module fpl_top_tb
	import fpl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic            sys_clk_i = 1'b0;
	logic            rst_i = 1'b1;
	logic [AW-1:0]   awaddr = '0, araddr = '0;
	logic            awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0]     wdata = '0, rdata;
	logic            ref_in = 0, phase_valid = 0, report_req = 0;
	logic [PH_W-1:0] phase = '0, filt;
	logic [NKEY-1:0] key;
	logic            lockout, awready, wready, bvalid, arready, rvalid;
	logic            ref_a, ref_b, lock_led, remote_led;
	logic [1:0]      bresp, rresp, view;
	int              error_cnt = 0, n_tests = 0, cyc = 0;

	always #50 sys_clk_i = ~sys_clk_i;

	fpl_top #(.SEC_CYCLES(2000)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .key_i(key),
		.remote_lockout_i(lockout), .ref_in_i(ref_in), .phase_sample_i(phase),
		.phase_valid_i(phase_valid), .report_req_i(report_req), .ref_a_o(ref_a),
		.ref_b_o(ref_b), .phase_filt_o(filt), .lock_led_o(lock_led),
		.remote_led_o(remote_led), .view_angle_o(view));

	fpl_panel_model u_pnl (.sys_clk_i(sys_clk_i), .key_o(key), .remote_lockout_o(lockout));

	// ---------------------------------------------------------------
	// Bus tasks and compare
	// ---------------------------------------------------------------
	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshake seen at the falling edge is taken at the next rising edge
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge sys_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge sys_clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge sys_clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				chk(32'(r), 32'(er));
				break;
			end
		end
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge sys_clk_i);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk_i);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				chk(d, exp);
				chk(32'(r), 32'(er));
				break;
			end
		end
	endtask

	task automatic ref_gap(input int exp);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		ref_in <= 1'b1;
		@(negedge sys_clk_i);
		while (!ref_a)
			@(negedge sys_clk_i);
		while (!ref_b) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk(32'(n), 32'(exp));
		@(posedge sys_clk_i);
		ref_in <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		int seq[7] = '{K_MENU, K_DOWN, K_RIGHT, K_DOWN, K_RIGHT, K_RIGHT, K_DOWN};
		int seq_b[6] = '{K_MENU, K_LEFT, K_UP, K_LEFT, K_UP, K_MENU};
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		chk(32'({lock_led, remote_led, view}), 32'h0);
		rd(REG_NOW_DATE, 32'h00000101, RESP_OKAY);
		foreach (seq[i])
			u_pnl.press(seq[i]);
		rd(REG_EDIT_DATE, 32'h00630c01, RESP_OKAY);
		rd(REG_EDIT_TOD, 32'h00170000, RESP_OKAY);
		repeat (2100) @(posedge sys_clk_i);
		rd(REG_NOW_TOD, 32'h00000001, RESP_OKAY);
		rd(REG_EDIT_TOD, 32'h00170000, RESP_OKAY);
		u_pnl.press(K_ENTER);
		rd(REG_NOW_DATE, 32'h00630c01, RESP_OKAY);
		rd(REG_NOW_TOD, 32'h00170000, RESP_OKAY);
		@(posedge sys_clk_i);
		report_req <= 1'b1;
		@(posedge sys_clk_i);
		report_req <= 1'b0;
		rd(REG_STAMP_DATE, 32'h00630c01, RESP_OKAY);
		rd(REG_STAMP_TOD, 32'h00170000, RESP_OKAY);
		// Left wraps year to second; leaving by the menu key must not load
		foreach (seq_b[i])
			u_pnl.press(seq_b[i]);
		rd(REG_EDIT_TOD, 32'h00170101, RESP_OKAY);
		rd(REG_NOW_TOD, 32'h00170000, RESP_OKAY);
		u_pnl.press(K_LOCK);
		chk(32'(lock_led), 32'h1);
		u_pnl.press(K_VIEW);
		chk(32'(view), 32'h0);
		u_pnl.press(K_LOCK);
		chk(32'(lock_led), 32'h0);
		for (int i = 1; i <= 4; i++) begin
			u_pnl.press(K_VIEW);
			chk(32'(view), 32'(i % 4));
		end
		u_pnl.lockout(1'b1);
		chk(32'(remote_led), 32'h1);
		u_pnl.press(K_LOCK);
		u_pnl.press(K_VIEW);
		chk(32'({lock_led, view}), 32'h0);
		u_pnl.press(K_REL);
		chk(32'(remote_led), 32'h0);
		u_pnl.press(K_VIEW);
		chk(32'(view), 32'h1);
		u_pnl.lockout(1'b0);
		@(posedge sys_clk_i);
		phase <= 16'h0100;
		phase_valid <= 1'b1;
		@(posedge sys_clk_i);
		phase_valid <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk(32'(filt), 32'h8);
		rd(REG_FILT, 32'h00000008, RESP_OKAY);
		wr(REG_CTRL, 32'h00000001, RESP_OKAY);
		// Both family bits kept equal, so no mismatch flag
		rd(REG_STATUS, 32'h00000084, RESP_OKAY);
		ref_gap(REF_DLY_CYC);
		wr(REG_CTRL, 32'h00000000, RESP_OKAY);
		ref_gap(0);
		rd(8'h24, 32'h00000000, RESP_SLVERR);
		wr(8'h30, 32'h00000001, RESP_SLVERR);
		conclude();
	end

	// Hang guard, well above the few thousand cycles the sequence needs
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			conclude();
		end
	end
endmodule // fpl_top_tb
